//--- io_delay_serdes_logic.sv
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module io_delay_serdes_logic
	import io_logic_pkg::*;
#(
	parameter int unsigned MAX_TAPS_P = io_logic_pkg::MAX_TAPS
) (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [7:0]                      paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire logic                            pin_in_rise,
	input  wire logic                            pin_in_fall,
	output logic                                 pin_out_rise,
	output logic                                 pin_out_fall,
	output logic                                 pin_oe,
	output logic                                 term_on,
	output logic                                 in_buffer_low_power,
	output logic                                 in_delay_low_power,
	output logic      [io_logic_pkg::TAP_W:0]    in_delay_taps,
	output logic      [io_logic_pkg::TAP_W-1:0]  out_delay_taps,
	output logic                                 delay_chained,
	input  wire logic                            fabric_oe,
	input  wire logic                            in_tap_inc,
	input  wire logic                            in_tap_dec,
	input  wire logic                            out_tap_inc,
	input  wire logic                            out_tap_dec,
	output logic                                 fabric_rx_rise,
	output logic                                 fabric_rx_fall,
	output logic      [io_logic_pkg::WORD_W-1:0] fabric_rx_word,
	output logic                                 fabric_rx_valid,
	input  wire logic [io_logic_pkg::WORD_W-1:0] fabric_tx_word,
	input  wire logic                            fabric_tx_valid,
	output logic                                 fabric_tx_ready
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [31:0]       rdata;
		logic              cap_rise;
		logic              cap_fall;
		logic              out_rise;
		logic              out_fall;
		logic [WORD_W-1:0] rx_acc;
		logic [WORD_W-1:0] rx_word;
		logic [3:0]        rx_cnt;
		logic              rx_valid;
		logic [WORD_W-1:0] tx_sh;
		logic [3:0]        tx_rem;
	} io_state_t;

	io_state_t st_reg;
	io_state_t st_next;

	function automatic logic [3:0] width_bits(input logic [1:0] w);
		unique case (w)
			W_2:     width_bits = 4'h2;
			W_4:     width_bits = 4'h4;
			W_8:     width_bits = 4'h8;
			default: width_bits = 4'h1;
		endcase
	endfunction

	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == CTRL_OFS) || (a == IN_TAP_OFS) ||
			(a == OUT_TAP_OFS) || (a == STATUS_OFS) ||
			(a == RX_WORD_OFS);
	endfunction

	logic                 in_reg_en;
	logic                 out_reg_en;
	logic                 ddr_en;
	logic [1:0]           wsel;
	logic                 cascade;
	logic [3:0]           step;
	logic [3:0]           nbits;
	logic                 wr_acc;
	logic [TAP_W-1:0]     in_tap;
	logic [TAP_W-1:0]     out_tap;
	logic                 o_rise;
	logic                 o_fall;
	logic                 tx_take;

	assign in_reg_en  = st_reg.ctrl[IN_REG_BIT];
	assign out_reg_en = st_reg.ctrl[OUT_REG_BIT];
	assign ddr_en     = st_reg.ctrl[DDR_BIT];
	assign wsel       = st_reg.ctrl[WIDTH_LSB +: 2];
	assign cascade    = st_reg.ctrl[CASCADE_BIT];
	assign step       = ddr_en ? 4'h2 : 4'h1;
	assign nbits      = width_bits(wsel);
	assign wr_acc     = psel && penable && pwrite;

	// ==========================================================
	// Delay lines
	delay_tap_counter #(
		.MAX_TAPS_P (MAX_TAPS_P)
	) u_input_delay_line (
		.pclk       (pclk),
		.presetn    (presetn),
		.load       (wr_acc && paddr == IN_TAP_OFS),
		.load_value (pwdata[TAP_W-1:0]),
		.inc        (in_tap_inc),
		.dec        (in_tap_dec),
		.tap        (in_tap)
	);

	delay_tap_counter #(
		.MAX_TAPS_P (MAX_TAPS_P)
	) u_output_delay_line (
		.pclk       (pclk),
		.presetn    (presetn),
		.load       (wr_acc && paddr == OUT_TAP_OFS),
		.load_value (pwdata[TAP_W-1:0]),
		.inc        (out_tap_inc),
		.dec        (out_tap_dec),
		.tap        (out_tap)
	);

	// Chained: the output line is lent to the input direction
	assign in_delay_taps  = cascade ? {1'b0, in_tap} + {1'b0, out_tap}
		: {1'b0, in_tap};
	assign out_delay_taps = cascade ? 8'h00 : out_tap;
	assign delay_chained  = cascade;

	// ==========================================================
	// Pin control
	assign pin_oe  = fabric_oe;
	// Termination only makes sense while listening
	assign term_on = st_reg.ctrl[TERM_BIT] && !fabric_oe;
	assign in_buffer_low_power = st_reg.ctrl[BUF_LP_BIT];
	assign in_delay_low_power  = st_reg.ctrl[IDLY_LP_BIT];

	// Direct or captured input
	assign fabric_rx_rise = in_reg_en ? st_reg.cap_rise : pin_in_rise;
	assign fabric_rx_fall = in_reg_en ? st_reg.cap_fall : pin_in_fall;
	assign fabric_rx_word  = st_reg.rx_word;
	assign fabric_rx_valid = st_reg.rx_valid;

	// Serializer accepts a word while its last bits leave
	assign fabric_tx_ready = (wsel == W_OFF) || (st_reg.tx_rem <= step);
	assign tx_take = fabric_tx_valid && fabric_tx_ready && wsel != W_OFF;

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.cap_rise = pin_in_rise;
		st_next.cap_fall = pin_in_fall;
		o_rise = 1'b0;
		o_fall = 1'b0;
		// Deserializer
		st_next.rx_valid = 1'b0;
		if (wsel == W_OFF) begin
			st_next.rx_word  = {6'h00, fabric_rx_fall, fabric_rx_rise};
			st_next.rx_valid = 1'b1;
			st_next.rx_cnt   = 4'h0;
		end else if (!fabric_oe) begin
			st_next.rx_acc[st_reg.rx_cnt[2:0]] = fabric_rx_rise;
			if (ddr_en) begin
				st_next.rx_acc[3'(st_reg.rx_cnt + 4'h1)] = fabric_rx_fall;
			end
			if (st_reg.rx_cnt + step >= nbits) begin
				st_next.rx_word  = st_next.rx_acc;
				st_next.rx_valid = 1'b1;
				st_next.rx_cnt   = 4'h0;
			end else begin
				st_next.rx_cnt = st_reg.rx_cnt + step;
			end
		end
		// Serializer, bit 0 leaves first
		if (wsel == W_OFF) begin
			o_rise = fabric_tx_word[0];
			o_fall = ddr_en ? fabric_tx_word[1] : fabric_tx_word[0];
		end else if (st_reg.tx_rem != 4'h0) begin
			o_rise = st_reg.tx_sh[0];
			o_fall = ddr_en ? st_reg.tx_sh[1] : st_reg.tx_sh[0];
			st_next.tx_sh  = ddr_en ? st_reg.tx_sh >> 2 : st_reg.tx_sh >> 1;
			st_next.tx_rem = st_reg.tx_rem - step;
		end
		if (tx_take) begin
			st_next.tx_sh  = fabric_tx_word;
			st_next.tx_rem = nbits;
		end
		st_next.out_rise = o_rise;
		st_next.out_fall = o_fall;
		// Registers
		if (wr_acc && paddr == CTRL_OFS) begin
			st_next.ctrl = pwdata[CTRL_W-1:0];
		end
		// Read data is captured in the setup cycle
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				CTRL_OFS:    st_next.rdata = {23'h0, st_reg.ctrl};
				IN_TAP_OFS:  st_next.rdata = {24'h0, in_tap};
				OUT_TAP_OFS: st_next.rdata = {24'h0, out_tap};
				STATUS_OFS:  st_next.rdata = {29'h0,
					st_reg.tx_rem != 4'h0, term_on, pin_oe};
				RX_WORD_OFS: st_next.rdata = {24'h0, st_reg.rx_word};
				default:     st_next.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '{ctrl: CTRL_RESET, rdata: 32'h0, rx_cnt: 4'h0,
				rx_acc: 8'h00, rx_word: 8'h00, tx_sh: 8'h00,
				tx_rem: 4'h0, default: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// Registered or direct output; the direct one is combinational
	assign pin_out_rise = out_reg_en ? st_reg.out_rise : o_rise;
	assign pin_out_fall = out_reg_en ? st_reg.out_fall : o_fall;

	assign prdata  = st_reg.rdata;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addr_hit(paddr);

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic w8s;
	assign w8s = wsel == W_8 && !ddr_en && !fabric_oe;

	term_off_drive_a: assert property (
		pin_oe |-> !term_on)
		else $error("termination on while driving");
	rx_hold_oe_a: assert property (
		fabric_oe && wsel != W_OFF |=> !fabric_rx_valid &&
		$stable(st_reg.rx_cnt))
		else $error("deserializer moved while driving");
	in_direct_a: assert property (
		!in_reg_en |-> fabric_rx_rise == pin_in_rise)
		else $error("direct input path not direct");
	in_captured_a: assert property (
		in_reg_en && $past(in_reg_en) |->
		fabric_rx_fall == $past(pin_in_fall))
		else $error("captured input not one cycle late");
	sdr_same_bit_a: assert property (
		!ddr_en && !out_reg_en |-> pin_out_fall == pin_out_rise)
		else $error("single rate output differs between edges");
	ddr_bypass_a: assert property (
		ddr_en && wsel == W_OFF && !out_reg_en |->
		pin_out_fall == fabric_tx_word[1])
		else $error("second edge bit wrong");
	word_gap_a: assert property (
		w8s && fabric_rx_valid |=> !fabric_rx_valid)
		else $error("word came early");
	word_rate_a: assert property (
		(w8s && fabric_rx_valid) ##1 w8s[*7] |=> fabric_rx_valid)
		else $error("word not after eight bits");
	tx_first_a: assert property (
		tx_take && !ddr_en && !out_reg_en ##1 wsel != W_OFF |->
		pin_out_rise == $past(fabric_tx_word[0]))
		else $error("first bit not shifted first");
	chain_sum_a: assert property (
		cascade |-> in_delay_taps == {1'b0, in_tap} + {1'b0, out_tap}
		&& out_delay_taps == 8'h00)
		else $error("chained delay not summed");

	cover_rx_word8: cover property (w8s && fabric_rx_valid);
	cover_tx_ddr: cover property (tx_take && ddr_en && wsel == W_4);
	cover_chain: cover property (cascade && in_delay_taps > 9'h0fa);
	cover_bad_addr: cover property (pslverr);
endmodule // io_delay_serdes_logic

//--- io_logic_pkg.sv
// Summary of operation
// - Each input and output path is chosen by configuration as direct or through a capture register.
// - Every input and output can carry two bits per clock, one per edge, in double data rate mode.
// - Each direction has its own delay line of up to 1250 ps total, in steps of 5 to 15 ps.
// - The tap count is loaded by configuration and the fabric may step it up or down by one in use.
// - The input and output delay lines can be chained to double the delay in one direction.
// - Each pin has a serializer and deserializer for 2, 4 or 8 bit fabric words.
// - A single-ended output drives high, drives low or floats under its three-state enable.
// - The receiver always runs, but its value is ignored while the pin's driver is enabled; here only the deserializer at widths 2, 4 or 8 ignores it.
// - Termination is on only while receiving, which includes while three-stated, and switches off when driving.
// - The input buffer and the input delay each have a selectable low-power mode.
package io_logic_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] IN_TAP_OFS  = 8'h04;
	localparam logic [7:0] OUT_TAP_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS  = 8'h0c;
	localparam logic [7:0] RX_WORD_OFS = 8'h10;
	// ==========================================================
	// Control fields
	localparam int IN_REG_BIT  = 0;
	localparam int OUT_REG_BIT = 1;
	localparam int DDR_BIT     = 2;
	localparam int WIDTH_LSB   = 3;
	localparam int CASCADE_BIT = 5;
	localparam int TERM_BIT    = 6;
	localparam int BUF_LP_BIT  = 7;
	localparam int IDLY_LP_BIT = 8;
	localparam int CTRL_W      = 9;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
	// Width codes: serdes off, 2, 4 or 8 bits
	localparam logic [1:0] W_OFF = 2'h0;
	localparam logic [1:0] W_2   = 2'h1;
	localparam logic [1:0] W_4   = 2'h2;
	localparam logic [1:0] W_8   = 2'h3;
	localparam int WORD_W = 8;
	// ==========================================================
	// Delay line
	localparam int TOTAL_DELAY_PS = 1250;
	localparam int TAP_MIN_PS     = 5;
	localparam int TAP_MAX_PS     = 15;
	localparam int MAX_TAPS       = TOTAL_DELAY_PS / TAP_MIN_PS;
	localparam int TAP_W          = 8;
	localparam logic [TAP_W-1:0] TAP_RESET = 8'h00;
endpackage

//--- delay_tap_counter.sv
`timescale 1ns/1ps
module delay_tap_counter
	import io_logic_pkg::*;
#(
	parameter int unsigned MAX_TAPS_P = io_logic_pkg::MAX_TAPS
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          load,
	input  wire logic [io_logic_pkg::TAP_W-1:0] load_value,
	input  wire logic                          inc,
	input  wire logic                          dec,
	output logic      [io_logic_pkg::TAP_W-1:0] tap
);
	localparam logic [TAP_W-1:0] TOP = TAP_W'(MAX_TAPS_P);

	typedef struct packed {
		logic [TAP_W-1:0] tap;
	} tap_state_t;

	tap_state_t st_reg;
	tap_state_t st_next;

	always_comb begin
		st_next = st_reg;
		if (load) begin
			st_next.tap = (load_value > TOP) ? TOP : load_value;
		end else if (inc && !dec && st_reg.tap != TOP) begin
			st_next.tap = st_reg.tap + 8'h01;
		end else if (dec && !inc && st_reg.tap != 8'h00) begin
			st_next.tap = st_reg.tap - 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg.tap <= TAP_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tap = st_reg.tap;

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sat_at_max_a: assert property (
		!load && inc && !dec && tap == TOP |=> tap == TOP)
		else $error("tap wrapped above maximum");
	sat_at_min_a: assert property (
		!load && dec && !inc && tap == 8'h00 |=> tap == 8'h00)
		else $error("tap wrapped below zero");
	step_up_one_a: assert property (
		!load && inc && !dec && tap < TOP |=> tap == $past(tap) + 8'h01)
		else $error("increment did not step by one");
	load_taken_a: assert property (
		load && load_value <= TOP |=> tap == $past(load_value))
		else $error("configured tap count not loaded");
	cover_saturate: cover property (tap == TOP ##1 inc ##1 tap == TOP);
endmodule // delay_tap_counter

//--- pin_partner.sv
`timescale 1ns/1ps
// ==========================================================
// Far-side component on the pad
module pin_partner (
	input  wire logic pin_oe,
	input  wire logic pin_out_rise,
	input  wire logic pin_out_fall,
	input  wire logic far_rise,
	input  wire logic far_fall,
	output logic      pin_in_rise,
	output logic      pin_in_fall
);
	// Receiver stays live, so our own drive reads back while enabled
	assign pin_in_rise = pin_oe ? pin_out_rise : far_rise;
	assign pin_in_fall = pin_oe ? pin_out_fall : far_fall;
endmodule // pin_partner

//--- testbench.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the pin logic
module testbench;
	import io_logic_pkg::*;
	localparam int         MAXT = 8;
	localparam logic [3:0] PAT  = 4'hb;
	localparam logic [7:0] TXW  = 8'h0d;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pin_in_rise, pin_in_fall, pin_out_rise, pin_out_fall;
	logic        pin_oe, term_on, in_buffer_low_power, in_delay_low_power;
	logic [8:0]  in_delay_taps;
	logic [7:0]  out_delay_taps, fabric_rx_word, fabric_tx_word;
	logic        delay_chained, fabric_oe, far_rise, far_fall;
	logic [3:0]  tap_req;
	logic        fabric_rx_rise, fabric_rx_fall, fabric_rx_valid;
	logic        fabric_tx_valid, fabric_tx_ready;
	int          n_mismatch, checks;

	io_delay_serdes_logic #(.MAX_TAPS_P(MAXT)) u_io_delay_serdes_logic (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in_rise(pin_in_rise),
		.pin_in_fall(pin_in_fall), .pin_out_rise(pin_out_rise),
		.pin_out_fall(pin_out_fall), .pin_oe(pin_oe), .term_on(term_on),
		.in_buffer_low_power(in_buffer_low_power),
		.in_delay_low_power(in_delay_low_power),
		.in_delay_taps(in_delay_taps), .out_delay_taps(out_delay_taps),
		.delay_chained(delay_chained), .fabric_oe(fabric_oe),
		.in_tap_inc(tap_req[3]), .in_tap_dec(tap_req[2]),
		.out_tap_inc(tap_req[1]), .out_tap_dec(tap_req[0]),
		.fabric_rx_rise(fabric_rx_rise), .fabric_rx_fall(fabric_rx_fall),
		.fabric_rx_word(fabric_rx_word), .fabric_rx_valid(fabric_rx_valid),
		.fabric_tx_word(fabric_tx_word), .fabric_tx_valid(fabric_tx_valid),
		.fabric_tx_ready(fabric_tx_ready));

	pin_partner u_pin_partner (.pin_oe(pin_oe), .pin_out_rise(pin_out_rise),
		.pin_out_fall(pin_out_fall), .far_rise(far_rise),
		.far_fall(far_fall), .pin_in_rise(pin_in_rise),
		.pin_in_fall(pin_in_fall));

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n++ < 50) @(posedge pclk);
		if (n >= 50) begin
			n_mismatch++;
			results;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
	endtask

	// Holds a tap request for n level cycles, then lets it land
	task automatic step(input logic [3:0] s, input int n);
		repeat (n) @(posedge pclk) tap_req <= s;
		@(posedge pclk);
		tap_req <= 4'h0;
		@(posedge pclk);
		#1;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		logic [31:0] r;
		logic        e;
		rd(CTRL_OFS, 32'h0);
		apb(1'b0, 8'h20, 32'h0, r, e);
		chk(32'(e), 32'h1);
		wr(CTRL_OFS, 32'h1ff);
		rd(CTRL_OFS, 32'h1ff);
		chk({30'h0, in_delay_low_power, in_buffer_low_power}, 32'h3);
		chk(32'(pready), 32'h1);
		$display("test regs done");
	endtask

	task automatic t_taps;
		wr(CTRL_OFS, 32'h0);
		wr(IN_TAP_OFS, 32'hff);
		rd(IN_TAP_OFS, MAXT);
		step(4'h8, 2);
		chk(32'(in_delay_taps), MAXT);
		step(4'h4, MAXT + 3);
		chk(32'(in_delay_taps), 32'h0);
		step(4'h8, 3);
		chk(32'(in_delay_taps), 32'h3);
		wr(OUT_TAP_OFS, 32'h2);
		step(4'h2, 1);
		chk(32'(out_delay_taps), 32'h3);
		step(4'h1, 2);
		wr(CTRL_OFS, 32'h20);
		chk({22'h0, delay_chained, in_delay_taps}, 32'h204);
		chk(32'(out_delay_taps), 32'h0);
		$display("test taps done");
	endtask

	task automatic t_term;
		wr(CTRL_OFS, 32'h40);
		chk({30'h0, term_on, pin_oe}, 32'h2);
		rd(STATUS_OFS, 32'h2);
		@(posedge pclk);
		fabric_oe <= 1'b1;
		#1;
		chk({30'h0, term_on, pin_oe}, 32'h1);
		rd(STATUS_OFS, 32'h1);
		$display("test term done");
	endtask

	task automatic t_tx;
		int n;
		for (int k = 0; k < 2; k++) begin
			// Second pass goes through the output register: one more cycle
			wr(CTRL_OFS, 32'({W_4, 1'b0, 1'(k), 1'b0}));
			n = 0;
			@(posedge pclk);
			fabric_tx_word <= TXW;
			fabric_tx_valid <= 1'b1;
			@(posedge pclk);
			while (fabric_tx_ready !== 1'b1 && n++ < 20) @(posedge pclk);
			if (n >= 20) n_mismatch++;
			fabric_tx_valid <= 1'b0;
			repeat (k) @(posedge pclk);
			// Look mid-cycle, where the bit has settled
			for (int i = 0; i < 4; i++) begin
				@(negedge pclk);
				chk({pin_out_rise, pin_out_fall}, {2{TXW[i]}});
			end
		end
		$display("test tx done");
	endtask

	task automatic t_rx;
		int n;
		n = 0;
		@(posedge pclk);
		fabric_oe <= 1'b0;
		wr(CTRL_OFS, 32'(W_4) << WIDTH_LSB);
		@(posedge pclk);
		while (fabric_rx_valid !== 1'b1 && n++ < 20) @(posedge pclk);
		if (n >= 20) n_mismatch++;
		n = 0;
		// Word boundary sits one bit behind the pulse edge
		for (int i = 0; i < 12; i++) begin
			far_rise <= PAT[(i + 1) % 4];
			@(posedge pclk);
			if (i > 4 && fabric_rx_valid === 1'b1) begin
				chk(32'(fabric_rx_word[3:0]), 32'(PAT));
				n++;
			end
		end
		chk(n, 2);
		$display("test rx done");
	endtask

	task automatic t_ddr;
		wr(CTRL_OFS, 32'h4);
		@(posedge pclk);
		far_rise <= 1'b1;
		far_fall <= 1'b0;
		fabric_tx_word <= 8'h02;
		#1;
		chk({fabric_rx_rise, fabric_rx_fall}, 32'h2);
		chk({pin_out_rise, pin_out_fall}, 32'h1);
		@(posedge pclk);
		#1;
		chk(32'(fabric_rx_word[1:0]), 32'h1);
		wr(CTRL_OFS, 32'h5);
		@(posedge pclk);
		far_rise <= 1'b0;
		far_fall <= 1'b1;
		#1;
		chk({fabric_rx_rise, fabric_rx_fall}, 32'h2);
		@(posedge pclk);
		#1;
		chk({fabric_rx_rise, fabric_rx_fall}, 32'h1);
		$display("test ddr done");
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// ==========================================================
	// Clock, sequence and watchdog
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		{presetn, psel, penable, pwrite, fabric_oe} = 5'h0;
		{far_rise, far_fall, fabric_tx_valid} = 3'h0;
		{paddr, pwdata, fabric_tx_word, tap_req} = 52'h0;
		{n_mismatch, checks} = 64'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_taps;
		t_term;
		t_tx;
		t_rx;
		t_ddr;
		results;
	end

	// Tests need well under 1000 cycles
	initial begin
		#50us;
		n_mismatch++;
		results;
	end
endmodule // testbench
